//--- logic/dlc_pkg.sv
// constants and types of the display-list coprocessor
//----------------------------------------------------------------
// Functional notes
//----------------------------------------------------------------
// Functional notes
// - guard bit set: MOVE reaches every register; clear: only offsets above 7E
// - power-on reset clears the guard bit
// - writing restart strobe one or two loads the PC from pointer one or two
// - the coprocessor's own MOVE to a restart strobe also jumps
// - each jump pointer holds a 20-bit chip-memory address for the PC
// - pointers are written as a 5-bit high half and a 15-bit low half
// - every instruction fetch drives marker address 08C, except MOVE second word
// - first word bit 0 clear means MOVE; bits 8..1 destination, word two data
// - destination captured at first word; data driven to it at second word
// - WAIT/SKIP: word one bit 0 set, V in 15..8, H 8..2 in 7..1
// - WAIT keeps off the bus until beam reaches the masked target
// - SKIP skips the next MOVE when the beam has reached the target
// - word two bits 14..8, 7..1 are compare enables; top V bit always compared
// - word two bit 15 clear: blit-done must also hold; set: it is ignored
// - bus slots are requested only on odd memory cycles
// - two word fetches per instruction, four memory cycles of 280 ns
// - start of vertical blank reloads the PC from pointer one
// - fetching needs master DMA enable bit 9 and coprocessor enable bit 7
package dlc_pkg;
    //----------------------------------------------------------------
    // register offsets
    //----------------------------------------------------------------
    localparam logic [8:0]  OFS_CONTROL      = 9'h02E;
    localparam logic [8:0]  OFS_PTR_ONE_HI   = 9'h080;
    localparam logic [8:0]  OFS_PTR_ONE_LO   = 9'h082;
    localparam logic [8:0]  OFS_PTR_TWO_HI   = 9'h084;
    localparam logic [8:0]  OFS_PTR_TWO_LO   = 9'h086;
    localparam logic [8:0]  OFS_RESTART_ONE  = 9'h088;
    localparam logic [8:0]  OFS_RESTART_TWO  = 9'h08A;
    localparam logic [8:0]  OFS_FETCH_MARKER = 9'h08C;
    localparam logic [8:0]  OFS_GUARD_LIMIT  = 9'h07E;
    //----------------------------------------------------------------
    // fields and reset values
    //----------------------------------------------------------------
    localparam int          CTRL_ALLOW_BIT   = 1;
    localparam logic        CTRL_ALLOW_RST   = 1'b0;
    localparam int          DMA_MASTER_BIT   = 9;
    localparam int          DMA_COPPER_BIT   = 7;
    localparam int          PTR_HI_W         = 5;
    localparam int          PTR_LO_W         = 15;
    localparam int          PC_W_DOC         = PTR_HI_W + PTR_LO_W;
    localparam int          BLIT_IGNORE_BIT  = 15;
    //----------------------------------------------------------------
    // timing
    //----------------------------------------------------------------
    localparam int          CLK_PERIOD_PS    = 4000;
    localparam int          MEM_CYCLE_PS     = 280000;
    localparam int          MEM_CYCLE_CLKS   = (MEM_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          MEM_CYCLES_INSN  = 4;
    //----------------------------------------------------------------
    // sequencer states
    //----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_FETCH1 = 2'b00,
        ST_FETCH2 = 2'b01,
        ST_WAIT   = 2'b10,
        ST_HALT   = 2'b11
    } dlc_state_t;
endpackage : dlc_pkg

//--- logic/dlc_cmp_if.sv
// beam comparison carrier between sequencer and comparator
`timescale 1ns/1ps
interface dlc_cmp_if;
    logic [15:0] word1;
    logic [15:0] word2;
    logic [7:0]  beam_v;
    logic [8:0]  beam_h;
    logic        blit_done;
    logic        hit;
    modport cmp (input word1, input word2, input beam_v, input beam_h, input blit_done, output hit);
    modport ctl (output word1, output word2, output beam_v, output beam_h, output blit_done, input hit);
endinterface : dlc_cmp_if

//--- logic/dlc_beam_cmp.sv
// masked beam position comparator
`timescale 1ns/1ps
module dlc_beam_cmp
    import dlc_pkg::*;
(
    dlc_cmp_if.cmp cif
);
    logic [14:0] mask;
    logic [14:0] target;
    logic [14:0] beam;

    //----------------------------------------------------------------
    // compare
    //----------------------------------------------------------------
    assign mask   = {1'b1, cif.word2[14:8], cif.word2[7:1]};
    assign target = {cif.word1[15:8], cif.word1[7:1]} & mask;
    assign beam   = {cif.beam_v, cif.beam_h[8:2]} & mask;
    assign cif.hit = (beam >= target) && (cif.word2[BLIT_IGNORE_BIT] || cif.blit_done);
endmodule : dlc_beam_cmp

//--- logic/dlc_coproc.sv
// display-list coprocessor: fetch, decode and execute
`timescale 1ns/1ps
module dlc_coproc
    import dlc_pkg::*;
#(
    parameter int PC_W = PC_W_DOC
)
(
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    // processor register writes
    input  wire logic              cpu_wr_en,
    input  wire logic [8:0]        cpu_wr_addr,
    input  wire logic [15:0]       cpu_wr_data,
    // system state
    input  wire logic [15:0]       dma_control,
    input  wire logic              vblank_start,
    input  wire logic              blit_done,
    input  wire logic [7:0]        beam_v,
    input  wire logic [8:0]        beam_h,
    // chip memory slot
    input  wire logic              slot_odd,
    input  wire logic              dma_grant,
    input  wire logic [15:0]       mem_data,
    output logic                   dma_req_r,
    output logic [PC_W-1:0]        dma_addr_r,
    // chip register bus
    output logic [8:0]             rbus_addr_r,
    output logic [15:0]            rbus_data_r,
    output logic                   rbus_wr_r
);
    //----------------------------------------------------------------
    // checks and decode
    //----------------------------------------------------------------
    if (PC_W != PC_W_DOC) begin : g_bad_pc
        $error("dlc_coproc: PC_W must equal the pointer width");
    end

    function automatic logic is_move(input logic [15:0] w);
        return !w[0];
    endfunction : is_move

    function automatic logic reg_hit(input logic en, input logic [8:0] a, input logic [8:0] ofs);
        return en && (a == ofs);
    endfunction : reg_hit

    dlc_state_t         state_r;
    logic [PC_W-1:0]    pc_r;
    logic [PC_W-1:0]    ptr_one_r;
    logic [PC_W-1:0]    ptr_two_r;
    logic               allow_r;
    logic [15:0]        word1_r;
    logic [15:0]        word2_r;
    logic               skip_r;
    logic               dma_ok;
    logic               fetching;
    logic               grant1;
    logic               grant2;
    logic               own_wr;
    logic [8:0]         own_addr;
    logic               strobe_one;
    logic               strobe_two;
    logic               restart;
    logic               dma_req_nxt;
    logic               guarded;

    //----------------------------------------------------------------
    // comparator
    //----------------------------------------------------------------
    dlc_cmp_if cmp_bus();
    assign cmp_bus.word1     = word1_r;
    assign cmp_bus.word2     = word2_r;
    assign cmp_bus.beam_v    = beam_v;
    assign cmp_bus.beam_h    = beam_h;
    assign cmp_bus.blit_done = blit_done;

    dlc_beam_cmp u_cmp (
        .cif (cmp_bus.cmp)
    );

    //----------------------------------------------------------------
    // combinational control
    //----------------------------------------------------------------
    assign dma_ok     = dma_control[DMA_MASTER_BIT] && dma_control[DMA_COPPER_BIT];
    assign fetching   = (state_r == ST_FETCH1) || (state_r == ST_FETCH2);
    assign grant1     = dma_req_r && dma_grant && (state_r == ST_FETCH1);
    assign grant2     = dma_req_r && dma_grant && (state_r == ST_FETCH2);
    assign own_addr   = {word1_r[8:1], 1'b0};
    assign own_wr     = grant2 && is_move(word1_r) && !skip_r;
    assign guarded    = !allow_r && ({mem_data[8:1], 1'b0} <= OFS_GUARD_LIMIT);
    assign strobe_one = reg_hit(cpu_wr_en, cpu_wr_addr, OFS_RESTART_ONE)
                     || reg_hit(own_wr, own_addr, OFS_RESTART_ONE);
    assign strobe_two = reg_hit(cpu_wr_en, cpu_wr_addr, OFS_RESTART_TWO)
                     || reg_hit(own_wr, own_addr, OFS_RESTART_TWO);
    assign restart    = strobe_one || strobe_two || vblank_start;
    assign dma_req_nxt = fetching && !restart && !dma_grant && dma_ok && slot_odd;

    //----------------------------------------------------------------
    // control register and jump pointers
    //----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            allow_r <= CTRL_ALLOW_RST;
        end else if (clk_en) begin
            if (reg_hit(own_wr, own_addr, OFS_CONTROL)) begin
                allow_r <= mem_data[CTRL_ALLOW_BIT];
            end else if (reg_hit(cpu_wr_en, cpu_wr_addr, OFS_CONTROL)) begin
                allow_r <= cpu_wr_data[CTRL_ALLOW_BIT];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ptr_one_r <= '0;
            ptr_two_r <= '0;
        end else if (clk_en) begin
            if (reg_hit(cpu_wr_en, cpu_wr_addr, OFS_PTR_ONE_HI)) begin
                ptr_one_r[PC_W-1:PTR_LO_W] <= cpu_wr_data[PTR_HI_W-1:0];
            end
            if (reg_hit(cpu_wr_en, cpu_wr_addr, OFS_PTR_ONE_LO)) begin
                ptr_one_r[PTR_LO_W-1:0] <= cpu_wr_data[PTR_LO_W-1:0];
            end
            if (reg_hit(cpu_wr_en, cpu_wr_addr, OFS_PTR_TWO_HI)) begin
                ptr_two_r[PC_W-1:PTR_LO_W] <= cpu_wr_data[PTR_HI_W-1:0];
            end
            if (reg_hit(cpu_wr_en, cpu_wr_addr, OFS_PTR_TWO_LO)) begin
                ptr_two_r[PTR_LO_W-1:0] <= cpu_wr_data[PTR_LO_W-1:0];
            end
            if (reg_hit(own_wr, own_addr, OFS_PTR_ONE_HI)) begin
                ptr_one_r[PC_W-1:PTR_LO_W] <= mem_data[PTR_HI_W-1:0];
            end
            if (reg_hit(own_wr, own_addr, OFS_PTR_ONE_LO)) begin
                ptr_one_r[PTR_LO_W-1:0] <= mem_data[PTR_LO_W-1:0];
            end
            if (reg_hit(own_wr, own_addr, OFS_PTR_TWO_HI)) begin
                ptr_two_r[PC_W-1:PTR_LO_W] <= mem_data[PTR_HI_W-1:0];
            end
            if (reg_hit(own_wr, own_addr, OFS_PTR_TWO_LO)) begin
                ptr_two_r[PTR_LO_W-1:0] <= mem_data[PTR_LO_W-1:0];
            end
        end
    end

    //----------------------------------------------------------------
    // program counter
    //----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pc_r <= '0;
        end else if (clk_en) begin
            if (strobe_two) begin
                pc_r <= ptr_two_r;
            end else if (strobe_one || vblank_start) begin
                pc_r <= ptr_one_r;
            end else if (grant1 || grant2) begin
                pc_r <= pc_r + PC_W'(1);
            end
        end
    end

    //----------------------------------------------------------------
    // sequencer
    //----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_HALT;
            word1_r <= '0;
            word2_r <= '0;
            skip_r  <= 1'b0;
        end else if (clk_en) begin
            if (restart) begin
                state_r <= ST_FETCH1;
                skip_r  <= 1'b0;
            end else begin
                case (state_r)
                    ST_FETCH1: begin
                        if (grant1) begin
                            word1_r <= mem_data;
                            if (is_move(mem_data) && guarded && !skip_r) begin
                                state_r <= ST_HALT;
                            end else begin
                                state_r <= ST_FETCH2;
                            end
                        end
                    end
                    ST_FETCH2: begin
                        if (grant2) begin
                            word2_r <= mem_data;
                            skip_r <= 1'b0;
                            state_r <= is_move(word1_r) ? ST_FETCH1 : ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        if (word2_r[0]) begin
                            skip_r  <= cmp_bus.hit;
                            state_r <= ST_FETCH1;
                        end else if (cmp_bus.hit) begin
                            state_r <= ST_FETCH1;
                        end
                    end
                    ST_HALT: begin
                        state_r <= ST_HALT;
                    end
                    default: begin
                        state_r <= ST_HALT;
                    end
                endcase
            end
        end
    end

    //----------------------------------------------------------------
    // memory request
    //----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dma_req_r  <= 1'b0;
            dma_addr_r <= '0;
        end else if (clk_en) begin
            dma_req_r <= dma_req_nxt;
            if (dma_req_nxt) begin
                dma_addr_r <= pc_r;
            end
        end
    end

    //----------------------------------------------------------------
    // register bus drive
    //----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rbus_addr_r <= OFS_FETCH_MARKER;
            rbus_data_r <= '0;
            rbus_wr_r   <= 1'b0;
        end else if (clk_en) begin
            rbus_wr_r <= own_wr;
            if (own_wr) begin
                rbus_addr_r <= own_addr;
                rbus_data_r <= mem_data;
            end else if (dma_req_nxt) begin
                if (state_r == ST_FETCH2 && is_move(word1_r)) begin
                    rbus_addr_r <= own_addr;
                end else begin
                    rbus_addr_r <= OFS_FETCH_MARKER;
                end
            end
        end
    end

    //----------------------------------------------------------------
    // checks
    //----------------------------------------------------------------
    sequence move_data_s;
        clk_en && grant2 && is_move(word1_r) && !skip_r;
    endsequence

    sequence bus_write_s;
        rbus_wr_r && (rbus_data_r == $past(mem_data)) && (rbus_addr_r == $past(own_addr));
    endsequence

    req_odd_slot_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(dma_req_r) |-> $past(slot_odd)) else $error("request outside odd slot");

    req_dma_en_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(dma_req_r) |-> $past(dma_ok)) else $error("request while DMA disabled");

    fetch_marker_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        dma_req_r && !(state_r == ST_FETCH2 && is_move(word1_r)) |-> rbus_addr_r == OFS_FETCH_MARKER)
        else $error("fetch without marker address");

    guard_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(rbus_wr_r) && !$past(allow_r) |-> rbus_addr_r > OFS_GUARD_LIMIT)
        else $error("guarded register written");

    reset_guard_a: assert property (@(posedge clk_sys)
        $past(!rst_n) |-> !allow_r) else $error("guard bit set after reset");

    restart_two_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && strobe_two |=> pc_r == $past(ptr_two_r) && state_r == ST_FETCH1)
        else $error("restart two did not load pointer two");

    vblank_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && vblank_start && !strobe_two |=> pc_r == $past(ptr_one_r))
        else $error("vertical blank did not reload pointer one");

    wait_holds_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && state_r == ST_WAIT && !word2_r[0] && !cmp_bus.hit && !restart |=> !dma_req_r [*2])
        else $error("wait left the bus early");

    skip_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && state_r == ST_WAIT && word2_r[0] && !restart |=> skip_r == $past(cmp_bus.hit))
        else $error("skip flag mismatch");

    move_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        move_data_s |=> bus_write_s) else $error("move data not driven");

    guard_halt_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        clk_en && grant1 && is_move(mem_data) && guarded && !skip_r && !restart |=> state_r == ST_HALT)
        else $error("guarded move did not halt");
endmodule : dlc_coproc

//--- verif/dlc_mem_model.sv
// chip memory slot model: odd-slot cadence, grants and program words
`timescale 1ns/1ps
module dlc_mem_model
    import dlc_pkg::*;
(
    // clock
    input  wire logic        clk_sys,
    // slot taken by a higher-ranked channel
    input  wire logic        steal,
    // coprocessor request
    input  wire logic        dma_req_r,
    input  wire logic [19:0] dma_addr_r,
    // slot answer
    output logic             slot_odd,
    output logic             dma_grant,
    output logic [15:0]      mem_data
);
    logic [15:0] mem [0:63];
    int          cnt = 0;

    initial begin
        slot_odd  = 1'b0;
        dma_grant = 1'b0;
        mem_data  = 16'h0000;
    end

    always @(negedge clk_sys) begin
        cnt       = (cnt + 1) % (2 * MEM_CYCLE_CLKS);
        // other channels outrank the coprocessor and may take its slot
        dma_grant = slot_odd && dma_req_r && !steal;
        // released bus toggles instead of holding the last word
        mem_data  = dma_grant ? mem[dma_addr_r[5:0]] : ~mem_data;
        slot_odd  = (cnt == 0);
    end
endmodule : dlc_mem_model

//--- verif/tb.sv
// self-checking bench of the display-list coprocessor
`timescale 1ns/1ps
module tb;
    import dlc_pkg::*;
    //--------------------------------
    // signals and bookkeeping
    //--------------------------------
    localparam int CYC_MAX = 80000;
    logic        clk_sys = 1'b0, rst_n = 1'b0, cpu_wr_en = 1'b0, vblank_start = 1'b0;
    logic        blit_done = 1'b1, steal = 1'b0, slot_prev = 1'b0, clk_en = 1'b1;
    logic [8:0]  cpu_wr_addr = 9'h000, beam_h = 9'h004;
    logic [15:0] cpu_wr_data = 16'h0000, dma_control = 16'h0080, d3;
    logic [7:0]  beam_v = 8'h20;
    logic        slot_odd, dma_grant, dma_req_r, rbus_wr_r;
    logic [15:0] mem_data, rbus_data_r;
    logic [19:0] dma_addr_r, pc;
    logic [8:0]  rbus_addr_r;
    logic [28:0] fq[$];
    logic [24:0] wq[$];
    int          mismatches = 0, samples_checked = 0, cyc = 0;

    dlc_coproc dlc_coproc_i (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .cpu_wr_en(cpu_wr_en),
        .cpu_wr_addr(cpu_wr_addr), .cpu_wr_data(cpu_wr_data), .dma_control(dma_control),
        .vblank_start(vblank_start), .blit_done(blit_done), .beam_v(beam_v), .beam_h(beam_h),
        .slot_odd(slot_odd), .dma_grant(dma_grant), .mem_data(mem_data), .dma_req_r(dma_req_r),
        .dma_addr_r(dma_addr_r), .rbus_addr_r(rbus_addr_r), .rbus_data_r(rbus_data_r), .rbus_wr_r(rbus_wr_r));
    dlc_mem_model dlc_mem_model_i (.clk_sys(clk_sys), .steal(steal), .dma_req_r(dma_req_r),
        .dma_addr_r(dma_addr_r), .slot_odd(slot_odd), .dma_grant(dma_grant), .mem_data(mem_data));

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    //--------------------------------
    // compare and stimulus tasks
    //--------------------------------
    task automatic fail(input string what, input logic [28:0] got, input logic [28:0] exp);
        mismatches++;
        $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    endtask : fail
    task automatic chk_fetch(input logic [19:0] a, input logic [8:0] m);
        logic [28:0] e;
        samples_checked++;
        e = (fq.size() == 0) ? 29'h1FFFFFFF : fq.pop_front();
        if (a !== e[28:9] || (e[8:0] != 9'h1FF && m !== e[8:0])) fail("fetch", {a, m}, e);
    endtask : chk_fetch
    task automatic chk_wr(input logic [24:0] g);
        logic [24:0] e;
        samples_checked++;
        e = (wq.size() == 0) ? 25'h1FFFFFF : wq.pop_front();
        if (g !== e) fail("register write", 29'(g), 29'(e));
    endtask : chk_wr
    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp) fail("pending count", 29'(got), 29'(exp));
    endtask : chk_cnt
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : idle
    task automatic cpu_wr(input logic [8:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        cpu_wr_addr = a;
        cpu_wr_data = d;
        cpu_wr_en   = 1'b1;
        @(negedge clk_sys);
        cpu_wr_en   = 1'b0;
    endtask : cpu_wr
    task automatic set_ptr(input bit two, input logic [19:0] p);
        logic [15:0] r;
        r = 16'($urandom);
        cpu_wr(two ? OFS_PTR_TWO_HI : OFS_PTR_ONE_HI, {r[10:0], p[19:15]});
        cpu_wr(two ? OFS_PTR_TWO_LO : OFS_PTR_ONE_LO, {r[15], p[14:0]});
    endtask : set_ptr
    task automatic ins(input logic [15:0] w1, input logic [15:0] w2, input bit run2, input bit wr);
        dlc_mem_model_i.mem[pc[5:0]] = w1;
        dlc_mem_model_i.mem[pc[5:0] + 6'h01] = w2;
        fq.push_back({pc, OFS_FETCH_MARKER});
        if (run2) fq.push_back({pc + 20'h1, w1[0] ? OFS_FETCH_MARKER : (wr ? {w1[8:1], 1'b0} : 9'h1FF)});
        if (wr) wq.push_back({w1[8:1], 1'b0, w2});
        pc = pc + 20'h2;
    endtask : ins
    task automatic term();
        ins(16'hFFFF, 16'hFFFE, 1'b1, 1'b0);
    endtask : term
    task automatic drain(input string name);
        for (int i = 0; i < 20000 && (fq.size() + wq.size()) > 0; i++) @(negedge clk_sys);
        idle(600);
        chk_cnt(fq.size() + wq.size(), 0);
        $display("test %s done", name);
    endtask : drain
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    //--------------------------------
    // output watcher
    //--------------------------------
    always @(negedge clk_sys) begin
        steal <= ($urandom % 4) == 0;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc > CYC_MAX) begin
            fail("timeout", 29'(cyc), 29'(CYC_MAX));
            give_verdict();
        end else begin
            if (rst_n && dma_req_r && !slot_prev) fail("request off slot", 29'h1, 29'h0);
            if (rst_n && clk_en && dma_req_r && dma_grant) chk_fetch(dma_addr_r, rbus_addr_r);
            if (rst_n && rbus_wr_r && !(rbus_addr_r inside {OFS_CONTROL, [OFS_PTR_ONE_HI:OFS_RESTART_TWO]})) begin
                chk_wr({rbus_addr_r, rbus_data_r});
            end
            slot_prev = slot_odd;
        end
    end
    //--------------------------------
    // scenarios
    //--------------------------------
    initial begin
        void'($urandom(32'h390E));
        idle(5);
        rst_n = 1'b1;
        pc = 20'h0;
        ins(16'h0040, 16'h1234, 1'b0, 1'b0);
        set_ptr(1'b0, 20'h00000);
        cpu_wr(OFS_RESTART_ONE, 16'($urandom));
        idle(600);
        chk_cnt(fq.size(), 1);
        dma_control = 16'h0200;
        idle(600);
        chk_cnt(fq.size(), 1);
        dma_control = 16'h0280;
        drain("guard clear halts");
        pc = 20'h0;
        ins(16'h0040, 16'($urandom), 1'b1, 1'b1);
        ins(16'h002E, 16'($urandom) & 16'hFFFD, 1'b1, 1'b0);
        ins(16'h0040, 16'($urandom), 1'b0, 1'b0);
        cpu_wr(OFS_CONTROL, 16'h0002);
        cpu_wr(OFS_RESTART_ONE, 16'($urandom));
        drain("guard set");
        pc = 20'h18020;
        ins(16'h0180, 16'($urandom), 1'b1, 1'b1);
        ins(16'h01FE, 16'($urandom), 1'b1, 1'b1);
        term();
        set_ptr(1'b1, 20'h18020);
        cpu_wr(OFS_RESTART_TWO, 16'($urandom));
        drain("pointer two");
        d3 = 16'($urandom);
        for (int k = 0; k < 2; k++) begin
            pc = 20'h10;
            ins(16'h0084, 16'h0000, 1'b1, 1'b0);
            ins(16'h0086, 16'h0030, 1'b1, 1'b0);
            ins(16'h008A, 16'h0000, 1'b1, 1'b0);
            pc = 20'h30;
            ins(16'h0184, d3, 1'b1, 1'b1);
            term();
            if (k == 0) set_ptr(1'b0, 20'h00010);
            if (k == 0) cpu_wr(OFS_RESTART_ONE, 16'h0000);
            @(negedge clk_sys);
            vblank_start = (k == 1);
            @(negedge clk_sys);
            vblank_start = 1'b0;
            drain(k == 0 ? "own strobe jump" : "vblank reload");
        end
        pc = 20'h0;
        ins(16'h4001, 16'h7F00, 1'b1, 1'b0);
        ins(16'h0186, 16'($urandom), 1'b1, 1'b1);
        term();
        set_ptr(1'b0, 20'h00000);
        cpu_wr(OFS_RESTART_ONE, 16'h0000);
        clk_en = 1'b0;
        idle(600);
        chk_cnt(fq.size(), 6);
        clk_en = 1'b1;
        idle(1500);
        chk_cnt(fq.size(), 4);
        beam_v = 8'h50;
        blit_done = 1'b0;
        idle(1500);
        chk_cnt(fq.size(), 4);
        blit_done = 1'b1;
        drain("wait");
        pc = 20'h0;
        ins(16'h8001, 16'h8001, 1'b1, 1'b0);
        ins(16'h0188, 16'($urandom), 1'b1, 1'b1);
        ins(16'h40FF, 16'hFFFF, 1'b1, 1'b0);
        ins(16'h018A, 16'($urandom), 1'b1, 1'b0);
        ins(16'h018C, 16'($urandom), 1'b1, 1'b1);
        term();
        cpu_wr(OFS_RESTART_ONE, 16'h0000);
        drain("skip");
        give_verdict();
    end
endmodule : tb
